// ===== ext_clock_detector.sv
`timescale 1ns/10ps
module ext_clock_detector #(
    parameter int TIMEOUT_CYC = pc_config_pkg::EXT_CLK_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // pin and control
    input wire logic clk_pin,
    input wire logic detect_en,
    // result
    output logic present
);
    import pc_config_pkg::*;

    localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);

    // a one-cycle window would drop the flag between pin edges
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("ext_clock_detector: TIMEOUT_CYC must be at least 2");
    end

    typedef enum logic [2:0] {
        DET_OFF = 3'h1,
        DET_ABSENT = 3'h2,
        DET_PRESENT = 3'h4
    } det_state_e;

    logic sync1_q;
    logic sync2_q;
    logic last_q;
    logic edge_seen;
    det_state_e state_q, state_d;
    logic [CNT_W-1:0] idle_q, idle_d;

    // pin is asynchronous; only sync2 and later are looked at
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            sync1_q <= clk_pin;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
        end
    end

    assign edge_seen = sync2_q & ~last_q;

    always_comb begin
        state_d = state_q;
        idle_d = idle_q;
        case (state_q)
            DET_OFF: begin
                idle_d = '0;
                if (detect_en) begin
                    state_d = DET_ABSENT;
                end
            end
            DET_ABSENT: begin
                idle_d = '0;
                if (edge_seen) begin
                    state_d = DET_PRESENT;
                end
            end
            DET_PRESENT: begin
                if (edge_seen) begin
                    idle_d = '0;
                end else if (idle_q == CNT_W'(TIMEOUT_CYC - 1)) begin
                    state_d = DET_ABSENT;
                    idle_d = '0;
                end else begin
                    idle_d = idle_q + CNT_W'(1);
                end
            end
            default: begin
                state_d = DET_OFF;
                idle_d = '0;
            end
        endcase
        // detection only runs while enabled
        if (!detect_en) begin
            state_d = DET_OFF;
            idle_d = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= DET_OFF;
            idle_q <= '0;
        end else begin
            state_q <= state_d;
            idle_q <= idle_d;
        end
    end

    assign present = (state_q == DET_PRESENT);

endmodule // ext_clock_detector

// ===== host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic [pc_config_pkg::ADDR_W-1:0] reg_addr,
    output logic [pc_config_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    // clock pin
    input wire logic pin_run,
    output logic clk_pin
);
    import pc_config_pkg::*;
    logic [1:0] div_q = 2'h0;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        clk_pin = 1'b0;
    end
    // pin held low between bursts, as a grounded pin would be
    always @(posedge ref_clk) begin
        div_q <= div_q + 2'h1;
        clk_pin <= pin_run & div_q[1];
    end
    // one request per edge; both strobes set every call so none is assigned twice
    task automatic op(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] data,
                      output logic [7:0] sent);
        sent = data;
        if (addr == CONFIG_ADDR && sent[PUMP_MSB]) sent[PWM_SAVE_BIT] = 1'b0;
        if (addr >= ENGINE_ONE_ADDR && addr <= ENGINE_THREE_ADDR && sent[6:0] > PC_MAX) sent[6:0] = PC_MAX;
        @(posedge ref_clk);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= addr;
        reg_wdata <= sent;
    endtask
endmodule // host_bus_model

// ===== pc_config_pkg.sv
package pc_config_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PC_W = 7;
    localparam int ENGINE_COUNT = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h36;
    localparam logic [ADDR_W-1:0] ENGINE_ONE_ADDR = 8'h37;
    localparam logic [ADDR_W-1:0] ENGINE_TWO_ADDR = 8'h38;
    localparam logic [ADDR_W-1:0] ENGINE_THREE_ADDR = 8'h39;

    // field positions in the power/pump/clock register
    localparam int POWER_SAVE_BIT = 5;
    localparam int PUMP_MSB = 4;
    localparam int PUMP_LSB = 3;
    localparam int PWM_SAVE_BIT = 2;
    localparam int CLK_SEL_MSB = 1;
    localparam int CLK_SEL_LSB = 0;

    // reset values and the start address maximum
    localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 7'h00;
    localparam logic [PC_W-1:0] PC_MAX = 7'h5f;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [1:0] {
        PUMP_OFF = 2'h0,
        PUMP_BYPASS_1X = 2'h1,
        PUMP_GAIN_1P5 = 2'h2,
        PUMP_AUTO = 2'h3
    } pump_mode_e;

    typedef enum logic [1:0] {
        CLK_FORCE_EXT = 2'h0,
        CLK_FORCE_INT = 2'h1,
        CLK_AUTO = 2'h2,
        CLK_INT = 2'h3
    } clk_sel_e;

    // external clock is declared lost after this long without an edge
    localparam int CLK_PERIOD_NS = 10;
    localparam int EXT_CLK_TIMEOUT_NS = 100000;
    localparam int EXT_CLK_TIMEOUT_CYC = EXT_CLK_TIMEOUT_NS / CLK_PERIOD_NS;

endpackage

// ===== pump_clock_engine_pc_config.sv
`timescale 1ns/10ps
module pump_clock_engine_pc_config #(
    parameter int TIMEOUT_CYC = pc_config_pkg::EXT_CLK_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register access from the serial bus front end
    input wire logic [pc_config_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pc_config_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pc_config_pkg::DATA_W-1:0] reg_rdata,
    // external clock pin
    input wire logic clk_pin,
    // power and pump control
    output logic power_save_enable,
    output logic [1:0] pump_gain_select,
    output logic pulse_width_saving_enable,
    // clock selection
    output logic external_clock_detect_enable,
    output logic internal_clock_enable,
    output logic external_clock_present_flag,
    output logic use_external_clock,
    // engine start addresses
    output logic [pc_config_pkg::PC_W-1:0] engine_one_start_address,
    output logic [pc_config_pkg::PC_W-1:0] engine_two_start_address,
    output logic [pc_config_pkg::PC_W-1:0] engine_three_start_address
);
    import pc_config_pkg::*;

    // engine index is two bits and readback packs an address into one byte
    if (ENGINE_COUNT > 4 || PC_W >= DATA_W) begin : g_bad_shape
        $error("pump_clock_engine_pc_config: engine count or address width unsupported");
    end
    if (TIMEOUT_CYC < 2) begin : g_bad_timeout
        $error("pump_clock_engine_pc_config: TIMEOUT_CYC must be at least 2");
    end

    function automatic logic is_engine_addr(input logic [ADDR_W-1:0] a);
        return (a >= ENGINE_ONE_ADDR) && (a <= ENGINE_THREE_ADDR);
    endfunction

    function automatic logic [1:0] engine_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ENGINE_ONE_ADDR;
        return off[1:0];
    endfunction

    logic [DATA_W-1:0] config_q, config_d;
    logic [PC_W-1:0] pc_q [ENGINE_COUNT], pc_d [ENGINE_COUNT];
    logic [DATA_W-1:0] rdata_q, rdata_d;
    clk_sel_e clk_sel;
    logic present;

    // register writes
    always_comb begin
        config_d = config_q;
        for (int i = 0; i < ENGINE_COUNT; i++) begin
            pc_d[i] = pc_q[i];
        end
        if (reg_wr && reg_addr == CONFIG_ADDR) begin
            config_d = reg_wdata;
        end
        // any 7-bit value is kept; range is up to software
        if (reg_wr && is_engine_addr(reg_addr)) begin
            pc_d[engine_index(reg_addr)] = reg_wdata[PC_W-1:0];
        end
    end

    // read data registered; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (reg_addr == CONFIG_ADDR) begin
                rdata_d = config_q;
            end else if (is_engine_addr(reg_addr)) begin
                rdata_d = {1'b0, pc_q[engine_index(reg_addr)]};
            end else begin
                rdata_d = UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_q <= CONFIG_RESET;
            for (int i = 0; i < ENGINE_COUNT; i++) begin
                pc_q[i] <= PC_RESET;
            end
            rdata_q <= UNMAPPED_READ;
        end else begin
            config_q <= config_d;
            for (int i = 0; i < ENGINE_COUNT; i++) begin
                pc_q[i] <= pc_d[i];
            end
            rdata_q <= rdata_d;
        end
    end

    ext_clock_detector #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_detector (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_pin(clk_pin),
        .detect_en(config_q[CLK_SEL_MSB]),
        .present(present)
    );

    assign clk_sel = clk_sel_e'(config_q[CLK_SEL_MSB:CLK_SEL_LSB]);

    // clock source choice
    always_comb begin
        case (clk_sel)
            CLK_FORCE_EXT: use_external_clock = 1'b1;
            CLK_FORCE_INT: use_external_clock = 1'b0;
            CLK_AUTO: use_external_clock = present;
            CLK_INT: use_external_clock = 1'b0;
            default: use_external_clock = 1'b0;
        endcase
    end

    // pwm saving is passed on as written; the pump-mode interlock is the host's job
    assign power_save_enable = config_q[POWER_SAVE_BIT];
    assign pump_gain_select = config_q[PUMP_MSB:PUMP_LSB];
    assign pulse_width_saving_enable = config_q[PWM_SAVE_BIT];
    assign external_clock_detect_enable = config_q[CLK_SEL_MSB];
    assign internal_clock_enable = config_q[CLK_SEL_LSB];
    assign external_clock_present_flag = present;
    assign engine_one_start_address = pc_q[0];
    assign engine_two_start_address = pc_q[1];
    assign engine_three_start_address = pc_q[2];
    assign reg_rdata = rdata_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_power_save;
        reg_wr && reg_addr == CONFIG_ADDR |=> power_save_enable == $past(reg_wdata[POWER_SAVE_BIT]);
    endproperty
    a_power_save: assert property (p_power_save) else $error("power save bit not taken");

    property p_pump_mode;
        reg_wr && reg_addr == CONFIG_ADDR |=> pump_gain_select == $past(reg_wdata[PUMP_MSB:PUMP_LSB]);
    endproperty
    a_pump_mode: assert property (p_pump_mode) else $error("pump mode not taken");

    property p_clk_forced;
        (clk_sel == CLK_FORCE_EXT |-> use_external_clock) and
        (clk_sel == CLK_FORCE_INT || clk_sel == CLK_INT |-> !use_external_clock);
    endproperty
    a_clk_forced: assert property (p_clk_forced) else $error("forced clock choice wrong");

    property p_clk_auto;
        clk_sel == CLK_AUTO |-> use_external_clock == external_clock_present_flag;
    endproperty
    a_clk_auto: assert property (p_clk_auto) else $error("auto clock choice wrong");

    property p_detect_off;
        !external_clock_detect_enable |=> !external_clock_present_flag;
    endproperty
    a_detect_off: assert property (p_detect_off) else $error("flag high with detection off");

    property p_pc_write;
        reg_wr && reg_addr == ENGINE_TWO_ADDR |=> engine_two_start_address == $past(reg_wdata[PC_W-1:0]);
    endproperty
    a_pc_write: assert property (p_pc_write) else $error("engine two address not taken");

    property p_pc_hold;
        !(reg_wr && is_engine_addr(reg_addr)) |=>
            $stable(engine_one_start_address) && $stable(engine_three_start_address);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("start address changed without write");

    property p_pc_read;
        reg_rd && !reg_wr && reg_addr == ENGINE_THREE_ADDR ##1 1 |->
            reg_rdata == {1'b0, $past(engine_three_start_address)};
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("engine three readback wrong");

    property p_unmapped;
        reg_rd && reg_addr != CONFIG_ADDR && !is_engine_addr(reg_addr) |=> reg_rdata == UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_clk_sel_write;
        reg_wr && reg_addr == CONFIG_ADDR |=>
            {external_clock_detect_enable, internal_clock_enable} == $past(reg_wdata[CLK_SEL_MSB:CLK_SEL_LSB]);
    endproperty
    a_clk_sel_write: assert property (p_clk_sel_write) else $error("clock select not taken");

    property p_config_hold;
        !(reg_wr && reg_addr == CONFIG_ADDR) |=>
            $stable(power_save_enable) && $stable(pump_gain_select) && $stable(pulse_width_saving_enable) &&
            $stable(external_clock_detect_enable) && $stable(internal_clock_enable);
    endproperty
    a_config_hold: assert property (p_config_hold) else $error("config changed without write");

    property p_pc_one_write;
        reg_wr && reg_addr == ENGINE_ONE_ADDR |=>
            engine_one_start_address == $past(reg_wdata[PC_W-1:0]) && $stable(engine_two_start_address);
    endproperty
    a_pc_one_write: assert property (p_pc_one_write) else $error("engine one address not taken");

    property p_config_read;
        reg_rd && !reg_wr && reg_addr == CONFIG_ADDR |=>
            reg_rdata[POWER_SAVE_BIT] == $past(power_save_enable) &&
            reg_rdata[PUMP_MSB:PUMP_LSB] == $past(pump_gain_select);
    endproperty
    a_config_read: assert property (p_config_read) else $error("config readback wrong");

    property p_flag_rise;
        $rose(external_clock_present_flag) |-> $past(external_clock_detect_enable);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag rose with detection off");

    c_auto_ext: cover property (clk_sel == CLK_AUTO && use_external_clock);
    c_pc_max: cover property (reg_wr && reg_addr == ENGINE_ONE_ADDR && reg_wdata[PC_W-1:0] == PC_MAX);
    c_pump_auto: cover property (pump_gain_select == PUMP_AUTO);
    c_flag_timeout: cover property ($fell(external_clock_present_flag) && external_clock_detect_enable);

endmodule // pump_clock_engine_pc_config

// ===== test_pump_clock_engine_pc_config.sv
`timescale 1ns/10ps
module test_pump_clock_engine_pc_config;
    import pc_config_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin_run = 1'b0;
    logic rd_took = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, clk_pin, power_save_enable, pulse_width_saving_enable;
    logic external_clock_detect_enable, internal_clock_enable, external_clock_present_flag, use_external_clock;
    logic [1:0] pump_gain_select;
    logic [6:0] engine_one_start_address, engine_two_start_address, engine_three_start_address;
    logic [7:0] shadow [0:3] = '{default: 8'h00};
    logic [7:0] expect_q [$];
    logic [31:0] lfsr_q = 32'd68525;
    int n_fail = 0;
    int checked = 0;
    always #5 ref_clk = ~ref_clk;
    host_bus_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .pin_run(pin_run), .clk_pin(clk_pin));
    pump_clock_engine_pc_config #(.TIMEOUT_CYC(20)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clk_pin(clk_pin), .power_save_enable(power_save_enable), .pump_gain_select(pump_gain_select),
        .pulse_width_saving_enable(pulse_width_saving_enable),
        .external_clock_detect_enable(external_clock_detect_enable),
        .internal_clock_enable(internal_clock_enable), .external_clock_present_flag(external_clock_present_flag),
        .use_external_clock(use_external_clock), .engine_one_start_address(engine_one_start_address),
        .engine_two_start_address(engine_two_start_address),
        .engine_three_start_address(engine_three_start_address));
    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // expectation noted at launch; a read in the same cycle as a write sees the old value
    task automatic access(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] sent;
        int i;
        u_host.op(wr, rd, addr, data, sent);
        i = int'(addr) - int'(CONFIG_ADDR);
        if (rd) expect_q.push_back((i >= 0 && i < 4) ? shadow[i] : UNMAPPED_READ);
        if (wr && i >= 0 && i < 4) shadow[i] = (i == 0) ? sent : {1'b0, sent[6:0]};
    endtask
    always @(posedge ref_clk) rd_took <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_took) begin
            if (expect_q.size() == 0) check("read_queue", 8'h01, 8'h00);
            else check("reg_rdata", reg_rdata, expect_q.pop_front());
        end
    end
    task automatic check_outputs(input logic exp_ext);
        access(1'b0, 1'b0, 8'h00, 8'h00);
        access(1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge ref_clk);
        check("config_out", {2'h0, power_save_enable, pump_gain_select, pulse_width_saving_enable,
            external_clock_detect_enable, internal_clock_enable}, {2'h0, shadow[0][5:0]});
        check("engine_one", {1'b0, engine_one_start_address}, shadow[1]);
        check("engine_two", {1'b0, engine_two_start_address}, shadow[2]);
        check("engine_three", {1'b0, engine_three_start_address}, shadow[3]);
        check("use_ext", {7'h0, use_external_clock}, {7'h0, exp_ext});
    endtask
    task automatic wait_flag(input logic level, input int bound);
        int n;
        n = 0;
        while (external_clock_present_flag !== level && n < bound) begin
            @(negedge ref_clk);
            n++;
        end
        check("present_flag", {7'h0, external_clock_present_flag}, {7'h0, level});
        // a flag that never reached its level ends the run as a failure
        if (external_clock_present_flag !== level) give_verdict();
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // reset values, unmapped neighbours included
        for (int a = 8'h34; a < 8'h3c; a++) access(1'b0, 1'b1, a[7:0], 8'h00);
        check_outputs(1'b1);
        for (int c = 0; c < 4; c++) begin
            access(1'b1, 1'b0, CONFIG_ADDR, {3'h1, c[1:0], 1'b1, c[1:0]});
            access(1'b0, 1'b1, CONFIG_ADDR, 8'h00);
            check_outputs(c == 0);
        end
        access(1'b1, 1'b0, ENGINE_ONE_ADDR, 8'hff);
        access(1'b1, 1'b0, ENGINE_THREE_ADDR, 8'h5f);
        access(1'b1, 1'b1, ENGINE_TWO_ADDR, 8'h2a);
        for (int a = 8'h37; a < 8'h3a; a++) access(1'b0, 1'b1, a[7:0], 8'h00);
        check_outputs(shadow[0][1:0] == CLK_FORCE_EXT);
        // random back-to-back traffic
        for (int k = 0; k < 300; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            access(lfsr_q[3], lfsr_q[4], 8'h34 + {5'h0, lfsr_q[2:0]}, lfsr_q[15:8]);
        end
        check_outputs(shadow[0][1:0] == CLK_FORCE_EXT);
        access(1'b1, 1'b0, CONFIG_ADDR, {6'h0, CLK_AUTO});
        check_outputs(1'b0);
        pin_run <= 1'b1;
        wait_flag(1'b1, 40);
        check_outputs(1'b1);
        pin_run <= 1'b0;
        wait_flag(1'b0, 80);
        check_outputs(1'b0);
        pin_run <= 1'b1;
        wait_flag(1'b1, 40);
        // detection off must drop the flag while the pin still runs
        access(1'b1, 1'b0, CONFIG_ADDR, {6'h0, CLK_FORCE_INT});
        wait_flag(1'b0, 4);
        check_outputs(1'b0);
        pin_run <= 1'b0;
        // second reset in mid-run brings every register back
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        shadow = '{default: 8'h00};
        access(1'b0, 1'b1, CONFIG_ADDR, 8'h00);
        access(1'b0, 1'b1, ENGINE_TWO_ADDR, 8'h00);
        check_outputs(1'b1);
        wait_flag(1'b0, 2);
        give_verdict();
    end
endmodule // test_pump_clock_engine_pc_config
